// [hw/eifb_top.sv]
/*
 * Event flags, packet buffer count and busy status of the Ethernet
 * controller's DMA side, with a plain register port.
 * Assumes all event inputs are one-cycle pulses from logic on mclk and
 * that software is the only register master.
 */
// Function
// - Transmit DMA bus error sets flag bit 14.
// - Receive DMA bus error sets flag bit 13.
// - Empty watermark flag bit 9 set at count <= level; hw increment clears.
// - Full watermark flag bit 8 set at count >= level; decrement clears.
// - Each successfully received packet sets flag bit 7.
// - Packet pending bit 6 follows nonzero count; writes ignored.
// - Receive data written into buffer-manager FIFO sets flag bit 5.
// - Transmit completion with status written sets flag bit 3.
// - MAC abandoning a transmit packet sets flag bit 2.
// - Receive descriptor overrun sets flag bit 1.
// - Receive FIFO overflow sets flag bit 0.
// - Event flags 14, 13, 7, 5 and 3-0 stay set until reset or a software clear: a zero by direct write, or a one via the clear or invert alias.
// - Count in bits 23-16 grows by descriptors used per received packet.
// - Count saturates at 0xFF and at zero, never wrapping.
// - Simultaneous increment and decrement leave the count unchanged.
// - At 0xFF with automatic flow control, receive halts until decremented.
// - Nonzero count interrupts only with packet pending enable set.
// - Writing the receive descriptor start address clears the count.
// - Switching the module off keeps the count.
// - Busy bit 7 high while on or finishing a transaction.
// - Transmit and receive active bits 6 and 5, forced low when off.
`timescale 1ns/1ps
module eifb_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic tx_bus_err_evt,
    input wire logic rx_bus_err_evt,
    input wire logic rx_done_evt,
    input wire logic [7:0] rx_desc_used,
    input wire logic rx_fifo_wr_evt,
    input wire logic tx_done_evt,
    input wire logic tx_abort_evt,
    input wire logic rx_bd_overrun_evt,
    input wire logic rx_fifo_ovf_evt,
    input wire logic tx_in_progress,
    input wire logic rx_in_progress,
    input wire logic txn_outstanding,
    output logic irq,
    output logic rx_halt,
    output logic module_on
);

    eifb_pkg::eifb_state_t s_q;
    eifb_pkg::eifb_state_t s_d;

    logic wr_irq;
    logic wr_clr;
    logic wr_set;
    logic wr_inv;
    logic wr_stat;
    logic wr_ien;
    logic wr_rxwm;
    logic wr_con1;
    logic wr_rxst;
    logic dec_req;
    logic inc_req;
    logic [14:0] hw_evt;
    logic [14:0] sw_flags;
    logic [7:0] cnt_n;

    // Adds with saturation at the top of the 8-bit count.
    function automatic logic [7:0] sat_add(input logic [7:0] a,
                                           input logic [7:0] b);
        logic [8:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        sat_add = sum[8] ? eifb_pkg::CNT_MAX : sum[7:0];
    endfunction

    // Subtracts one, holding at zero.
    function automatic logic [7:0] sat_dec(input logic [7:0] a);
        sat_dec = (a == 8'h00) ? 8'h00 : a - 8'h01;
    endfunction

    always_comb begin
        wr_irq = reg_wr && (reg_addr == eifb_pkg::OFS_IRQ);
        wr_clr = reg_wr && (reg_addr == eifb_pkg::OFS_IRQ_CLR);
        wr_set = reg_wr && (reg_addr == eifb_pkg::OFS_IRQ_SET);
        wr_inv = reg_wr && (reg_addr == eifb_pkg::OFS_IRQ_INV);
        wr_stat = reg_wr && (reg_addr == eifb_pkg::OFS_STAT);
        wr_ien = reg_wr && (reg_addr == eifb_pkg::OFS_IEN);
        wr_rxwm = reg_wr && (reg_addr == eifb_pkg::OFS_RXWM);
        wr_con1 = reg_wr && (reg_addr == eifb_pkg::OFS_CON1);
        wr_rxst = reg_wr && (reg_addr == eifb_pkg::OFS_RXST);
        dec_req = wr_con1 && reg_wdata[eifb_pkg::BIT_DEC];
        inc_req = rx_done_evt && (rx_desc_used != 8'h00);

        hw_evt = 15'h0000;
        hw_evt[eifb_pkg::BIT_TX_BUS_ERROR_FLAG] = tx_bus_err_evt;
        hw_evt[eifb_pkg::BIT_RX_BUS_ERROR_FLAG] = rx_bus_err_evt;
        hw_evt[eifb_pkg::BIT_RECEIVE_DONE_FLAG] = rx_done_evt;
        hw_evt[eifb_pkg::BIT_RECEIVE_ACTIVITY_FLAG] = rx_fifo_wr_evt;
        hw_evt[eifb_pkg::BIT_TRANSMIT_DONE_FLAG] = tx_done_evt;
        hw_evt[eifb_pkg::BIT_TRANSMIT_ABORT_FLAG] = tx_abort_evt;
        hw_evt[eifb_pkg::BIT_BDNA] = rx_bd_overrun_evt;
        hw_evt[eifb_pkg::BIT_OVF] = rx_fifo_ovf_evt;

        // Software edits of the sticky flags; hardware events win below.
        sw_flags = s_q.flags;
        if (wr_irq) begin
            sw_flags = reg_wdata[14:0];
        end
        if (wr_clr) begin
            sw_flags = s_q.flags & ~reg_wdata[14:0];
        end
        if (wr_set) begin
            sw_flags = s_q.flags | reg_wdata[14:0];
        end
        if (wr_inv) begin
            sw_flags = s_q.flags ^ reg_wdata[14:0];
        end

        // Count priority: start-address write, direct write, then events.
        if (wr_rxst) begin
            cnt_n = eifb_pkg::CNT_RST;
        end else if (wr_stat) begin
            cnt_n = reg_wdata[23:16];
        end else if (inc_req && dec_req) begin
            cnt_n = s_q.cnt;
        end else if (inc_req) begin
            cnt_n = sat_add(s_q.cnt, rx_desc_used);
        end else if (dec_req) begin
            cnt_n = sat_dec(s_q.cnt);
        end else begin
            cnt_n = s_q.cnt;
        end

        s_d = s_q;
        s_d.cnt = cnt_n;
        s_d.flags = ((sw_flags & eifb_pkg::STICKY_MASK) | hw_evt)
                    & eifb_pkg::STICKY_MASK;
        s_d.flags[eifb_pkg::BIT_PEND] = (cnt_n != 8'h00);
        s_d.flags[eifb_pkg::BIT_EWM] = inc_req ? 1'b0 :
            (s_q.flags[eifb_pkg::BIT_EWM]
             || (s_q.cnt <= s_q.ewm_lvl));
        s_d.flags[eifb_pkg::BIT_FWM] = dec_req ? 1'b0 :
            (s_q.flags[eifb_pkg::BIT_FWM]
             || (s_q.cnt >= s_q.fwm_lvl));

        if (wr_ien) begin
            s_d.ien = reg_wdata[14:0] & eifb_pkg::IEN_MASK;
        end
        if (wr_rxwm) begin
            s_d.fwm_lvl = reg_wdata[23:16];
            s_d.ewm_lvl = reg_wdata[7:0];
        end
        if (wr_con1) begin
            s_d.on = reg_wdata[eifb_pkg::BIT_ON];
            s_d.afc = reg_wdata[eifb_pkg::BIT_AFC];
        end

        // Receive stays halted while the count is full under flow control.
        s_d.halt = s_q.afc && (s_q.cnt == eifb_pkg::CNT_MAX);
        s_d.busy = s_q.on || txn_outstanding;
        s_d.tx_act = s_q.on && tx_in_progress;
        s_d.rx_act = s_q.on && rx_in_progress;
        s_d.irq = |(s_q.flags & s_q.ien);

        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                eifb_pkg::OFS_IRQ: begin
                    s_d.rdata = {17'h00000, s_q.flags};
                end
                eifb_pkg::OFS_STAT: begin
                    s_d.rdata = {8'h00, s_q.cnt, 8'h00, s_q.busy,
                                 s_q.tx_act, s_q.rx_act, 5'h00};
                end
                eifb_pkg::OFS_IEN: begin
                    s_d.rdata = {17'h00000, s_q.ien};
                end
                eifb_pkg::OFS_RXWM: begin
                    s_d.rdata = {8'h00, s_q.fwm_lvl, 8'h00, s_q.ewm_lvl};
                end
                eifb_pkg::OFS_CON1: begin
                    s_d.rdata = {16'h0000, s_q.on, 7'h00, s_q.afc, 7'h00};
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign rx_halt = s_q.halt;
    assign module_on = s_q.on;

    logic cnt_wr_any;
    assign cnt_wr_any = wr_rxst || wr_stat;

    logic irq_any;
    assign irq_any = |(s_q.flags & s_q.ien);

    sequence s_count_full;
        s_q.afc && (s_q.cnt == eifb_pkg::CNT_MAX);
    endsequence

    sequence s_halt_seen;
        ##1 rx_halt;
    endsequence

    AST_TX_BUS_ERROR_FLAG_SET: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_bus_err_evt |=> s_q.flags[eifb_pkg::BIT_TX_BUS_ERROR_FLAG])
        else $error("transmit bus error flag not set");

    AST_RX_BUS_ERROR_FLAG_SET: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_bus_err_evt |=> s_q.flags[eifb_pkg::BIT_RX_BUS_ERROR_FLAG])
        else $error("receive bus error flag not set");

    AST_EWM_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
        inc_req |=> !s_q.flags[eifb_pkg::BIT_EWM])
        else $error("empty watermark flag survived an increment");

    AST_FWM_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
        dec_req |=> !s_q.flags[eifb_pkg::BIT_FWM])
        else $error("full watermark flag survived a decrement");

    AST_RECEIVE_DONE_FLAG_SET: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_done_evt |=> s_q.flags[eifb_pkg::BIT_RECEIVE_DONE_FLAG])
        else $error("receive done flag not set");

    AST_PEND_LEVEL: assert property (@(posedge mclk) disable iff (!reset_n)
        s_q.flags[eifb_pkg::BIT_PEND] == (s_q.cnt != 8'h00))
        else $error("packet pending does not follow the count");

    AST_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
        s_q.flags[eifb_pkg::BIT_TRANSMIT_DONE_FLAG] && !reg_wr
        |=> s_q.flags[eifb_pkg::BIT_TRANSMIT_DONE_FLAG])
        else $error("transmit done flag dropped without a write");

    AST_CNT_INC: assert property (@(posedge mclk) disable iff (!reset_n)
        inc_req && !dec_req && !cnt_wr_any
        |=> s_q.cnt == sat_add($past(s_q.cnt), $past(rx_desc_used)))
        else $error("count did not grow by the descriptors used");

    AST_CNT_FLOOR: assert property (@(posedge mclk) disable iff (!reset_n)
        s_q.cnt == 8'h00 && dec_req && !inc_req && !cnt_wr_any
        |=> s_q.cnt == 8'h00)
        else $error("count rolled under");

    AST_CNT_BOTH: assert property (@(posedge mclk) disable iff (!reset_n)
        inc_req && dec_req && !cnt_wr_any |=> $stable(s_q.cnt))
        else $error("count moved on simultaneous increment and decrement");

    AST_HALT: assert property (@(posedge mclk) disable iff (!reset_n)
        s_count_full |-> s_halt_seen)
        else $error("receive not halted at full count");

    AST_RXST_CLR: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_rxst |=> s_q.cnt == eifb_pkg::CNT_RST)
        else $error("start address write did not clear the count");

    AST_OFF_KEEP: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(module_on) && !$past(inc_req) && !$past(dec_req)
        && !$past(cnt_wr_any)
        |-> s_q.cnt == $past(s_q.cnt))
        else $error("count lost when switched off");

    AST_BUSY_ON: assert property (@(posedge mclk) disable iff (!reset_n)
        module_on |=> s_q.busy)
        else $error("busy low while module on");

    AST_ACT_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
        !module_on |=> !s_q.tx_act && !s_q.rx_act)
        else $error("activity status high while module off");

    AST_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
        (|(s_q.flags & s_q.ien)) |=> irq)
        else $error("enabled flag did not raise the interrupt");

    AST_PEND_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
        irq |-> $past(irq_any))
        else $error("interrupt without an enabled flag");

endmodule

// [pkg/eifb_pkg.sv]
/*
 * Constants and the state type of the Ethernet event-flag and
 * buffer-count block.
 * Assumes a 32-bit register port with byte addresses on word boundaries.
 */
package eifb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] OFS_IRQ = 8'h00;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h04;
    localparam logic [7:0] OFS_IRQ_SET = 8'h08;
    localparam logic [7:0] OFS_IRQ_INV = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_IEN = 8'h14;
    localparam logic [7:0] OFS_RXWM = 8'h18;
    localparam logic [7:0] OFS_CON1 = 8'h1c;
    localparam logic [7:0] OFS_RXST = 8'h20;

    localparam int FLAG_W = 15;
    localparam int BIT_TX_BUS_ERROR_FLAG = 14;
    localparam int BIT_RX_BUS_ERROR_FLAG = 13;
    localparam int BIT_EWM = 9;
    localparam int BIT_FWM = 8;
    localparam int BIT_RECEIVE_DONE_FLAG = 7;
    localparam int BIT_PEND = 6;
    localparam int BIT_RECEIVE_ACTIVITY_FLAG = 5;
    localparam int BIT_TRANSMIT_DONE_FLAG = 3;
    localparam int BIT_TRANSMIT_ABORT_FLAG = 2;
    localparam int BIT_BDNA = 1;
    localparam int BIT_OVF = 0;
    localparam logic [14:0] STICKY_MASK = 15'h60af;
    localparam logic [14:0] IEN_MASK = 15'h63ef;

    localparam int CNT_LSB = 16;
    localparam int FWM_LSB = 16;
    localparam int EWM_LSB = 0;
    localparam int BIT_BUSY = 7;
    localparam int BIT_TXACT = 6;
    localparam int BIT_RECEIVE_ACTIVITY_FLAG_ST = 5;
    localparam int BIT_ON = 15;
    localparam int BIT_AFC = 7;
    localparam int BIT_DEC = 0;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [14:0] FLAG_RST = 15'h0000;

    typedef struct packed {
        logic [14:0] flags;
        logic [14:0] ien;
        logic [7:0] cnt;
        logic [7:0] ewm_lvl;
        logic [7:0] fwm_lvl;
        logic on;
        logic afc;
        logic halt;
        logic busy;
        logic tx_act;
        logic rx_act;
        logic irq;
        logic [31:0] rdata;
    } eifb_state_t;

endpackage

// [testbench/eth_irq_flags_buffer_count_tb.sv]
/*
 * Self-checking bench for the Ethernet event-flag and buffer-count block.
 * Assumes the register map and bit positions of eifb_pkg and a 200 MHz mclk.
 */
`timescale 1ns/1ps
module eth_irq_flags_buffer_count_tb;
    logic mclk;
    logic reset_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0] ev;
    logic [7:0] desc;
    logic tx_prog;
    logic rx_prog;
    logic txn_out;
    logic irq;
    logic rx_halt;
    logic module_on;
    logic [31:0] rv;
    int miscompares;
    int num_checks;
    int cycles;
    localparam int FBIT [8] = '{14, 13, 7, 5, 3, 2, 1, 0};
    localparam logic [31:0] STICKY = 32'(eifb_pkg::STICKY_MASK);

    eifb_top dut_u (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_bus_err_evt(ev[0]),
        .rx_bus_err_evt(ev[1]), .rx_done_evt(ev[2]), .rx_desc_used(desc),
        .rx_fifo_wr_evt(ev[3]), .tx_done_evt(ev[4]), .tx_abort_evt(ev[5]),
        .rx_bd_overrun_evt(ev[6]), .rx_fifo_ovf_evt(ev[7]),
        .tx_in_progress(tx_prog), .rx_in_progress(rx_prog),
        .txn_outstanding(txn_out), .irq(irq), .rx_halt(rx_halt),
        .module_on(module_on)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(rv & m, exp);
    endtask

    task automatic pulse(input logic [7:0] m, input logic [7:0] n);
        @(posedge mclk);
        ev <= m;
        desc <= n;
        @(posedge mclk);
        ev <= 8'h00;
        desc <= 8'h00;
    endtask

    task automatic irqchk(input logic exp);
        repeat (2) @(posedge mclk);
        #1;
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("ERROR at %0t: run did not finish in time", $time);
            tally_and_finish();
        end
    end

    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev = 8'h00;
        desc = 8'h00;
        tx_prog = 1'b0;
        rx_prog = 1'b0;
        txn_out = 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdchk(eifb_pkg::OFS_IRQ, 32'hfffffeff, 32'h200);
        rdchk(eifb_pkg::OFS_STAT, 32'hffffffff, 32'h0);
        rdchk(8'h24, 32'hffffffff, 32'h0);
        wr(eifb_pkg::OFS_IEN, 32'hffffffff);
        rdchk(eifb_pkg::OFS_IEN, 32'hffffffff, 32'(eifb_pkg::IEN_MASK));
        wr(eifb_pkg::OFS_IEN, 32'h0);
        wr(eifb_pkg::OFS_RXWM, 32'h00100000);
        rdchk(eifb_pkg::OFS_RXWM, 32'hffffffff, 32'h00100000);
        wr(eifb_pkg::OFS_CON1, 32'h1);
        rdchk(eifb_pkg::OFS_IRQ, 32'hffffffff, 32'h200);
        $display("test reset and map done");
        // Each event sets only its own flag, which outlives the pulse.
        for (int i = 0; i < 8; i++) begin
            pulse(8'(1 << i), 8'h00);
            repeat (3) @(posedge mclk);
            rdchk(eifb_pkg::OFS_IRQ, STICKY, 32'(1 << FBIT[i]));
            wr(eifb_pkg::OFS_IRQ_CLR, 32'(1 << FBIT[i]));
            rdchk(eifb_pkg::OFS_IRQ, STICKY, 32'h0);
        end
        $display("test sticky flags done");
        wr(eifb_pkg::OFS_IEN, 32'h1);
        wr(eifb_pkg::OFS_IRQ_SET, 32'h1);
        irqchk(1'b1);
        wr(eifb_pkg::OFS_IRQ_INV, 32'h1);
        rdchk(eifb_pkg::OFS_IRQ, STICKY, 32'h0);
        irqchk(1'b0);
        wr(eifb_pkg::OFS_IRQ_CLR, 32'h340);
        wr(eifb_pkg::OFS_IRQ, 32'h0);
        rdchk(eifb_pkg::OFS_IRQ, 32'h340, 32'h200);
        $display("test aliases and irq done");
        pulse(8'h04, 8'h03);
        rdchk(eifb_pkg::OFS_STAT, 32'hffffffff, 32'h00030000);
        rdchk(eifb_pkg::OFS_IRQ, 32'h3c0, 32'h0c0);
        wr(eifb_pkg::OFS_IEN, 32'h40);
        irqchk(1'b1);
        wr(eifb_pkg::OFS_IEN, 32'h0);
        irqchk(1'b0);
        repeat (4) wr(eifb_pkg::OFS_CON1, 32'h1);
        rdchk(eifb_pkg::OFS_STAT, 32'hffffffff, 32'h0);
        rdchk(eifb_pkg::OFS_IRQ, 32'h340, 32'h200);
        wr(eifb_pkg::OFS_STAT, 32'h000f0000);
        pulse(8'h04, 8'h01);
        rdchk(eifb_pkg::OFS_IRQ, 32'h300, 32'h100);
        wr(eifb_pkg::OFS_IRQ_CLR, 32'h100);
        rdchk(eifb_pkg::OFS_IRQ, 32'h300, 32'h100);
        wr(eifb_pkg::OFS_CON1, 32'h1);
        rdchk(eifb_pkg::OFS_IRQ, 32'h300, 32'h0);
        $display("test count and watermarks done");
        wr(eifb_pkg::OFS_CON1, 32'h8080);
        rdchk(eifb_pkg::OFS_CON1, 32'hffffffff, 32'h8080);
        wr(eifb_pkg::OFS_STAT, 32'h00fe0000);
        pulse(8'h04, 8'h05);
        rdchk(eifb_pkg::OFS_STAT, 32'h00ff0000, 32'h00ff0000);
        chk({31'h0, rx_halt}, 32'h1);
        @(posedge mclk);
        ev <= 8'h04;
        desc <= 8'h02;
        reg_wr <= 1'b1;
        reg_addr <= eifb_pkg::OFS_CON1;
        reg_wdata <= 32'h8081;
        @(posedge mclk);
        ev <= 8'h00;
        desc <= 8'h00;
        reg_wr <= 1'b0;
        rdchk(eifb_pkg::OFS_STAT, 32'h00ff0000, 32'h00ff0000);
        wr(eifb_pkg::OFS_CON1, 32'h8081);
        rdchk(eifb_pkg::OFS_STAT, 32'h00ff0000, 32'h00fe0000);
        chk({31'h0, rx_halt}, 32'h0);
        wr(eifb_pkg::OFS_CON1, 32'h0);
        rdchk(eifb_pkg::OFS_STAT, 32'hffffffff, 32'h00fe0000);
        $display("test saturation and flow control done");
        @(posedge mclk);
        tx_prog <= 1'b1;
        rx_prog <= 1'b1;
        wr(eifb_pkg::OFS_CON1, 32'h8000);
        rdchk(eifb_pkg::OFS_STAT, 32'he0, 32'he0);
        chk({31'h0, module_on}, 32'h1);
        @(posedge mclk);
        txn_out <= 1'b1;
        wr(eifb_pkg::OFS_CON1, 32'h0);
        rdchk(eifb_pkg::OFS_STAT, 32'he0, 32'h80);
        @(posedge mclk);
        txn_out <= 1'b0;
        rdchk(eifb_pkg::OFS_STAT, 32'he0, 32'h0);
        wr(eifb_pkg::OFS_RXST, 32'h00001234);
        rdchk(eifb_pkg::OFS_STAT, 32'h00ff0000, 32'h0);
        $display("test busy and start address done");
        tally_and_finish();
    end
endmodule
